//--- src/scc_top.sv
// Purpose: Serial configuration chain with shadow latches and field decode.
// Assumes: SER_CLK_I is the controller's clock and may stop between frames.
// Notes:   Chain and latches live on the serial clock; latched raw settings are
//          carried into the core clock through a stability synchroniser.
// Summary of operation
// - Fifty-four chain cells, fifty-three carry configuration.
// - Advance line high: shift right each rise.
// - Both lines low: every cell keeps value.
// - Readback line high: shadow copied in, wins.
// - Apply line high: latches take chain asynchronously.
// - Output cell clocked on falling serial edge.
// - Output cell holds during readback copy.
// - Shift and readback never touch active settings.
// - Serial output feeds next chip, loop closes.
// - Bits 0-7 are test-pulse mask, channel one first.
// - Bits 8-10 capacitor select, LSB bit 10.
// - Bits 11-18 timing threshold, LSB bit 18.
// - Bits 19-21 charge threshold, LSB bit 21.
// - Bits 22-25 hysteresis code, LSB bit 25.
// - Bits 26-29 integration gate, LSB bit 29.
// - Bits 30-32 rundown, 33-35 deadtime.
// - Bits 36-51 channel modes, bit 52 chip mode.
// - Rundown and charge threshold codes are inverted.
// - Forced modes drive channel output constant.
// - Each mask bit gates its channel's pulses.
`timescale 1ns/1ps
module scc_top
  import scc_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN
)(
  input  wire logic                CORE_CLK_I,
  input  wire logic                RST_N_I,
  input  wire logic                SER_CLK_I,
  input  wire logic                SER_DATA_I,
  input  wire logic                ADVANCE_CONTROL_LINE_I,
  input  wire logic                READBACK_CONTROL_LINE_I,
  input  wire logic                APPLY_CONTROL_LINE_I,
  input  wire logic [CHANNELS-1:0] CHAN_HIT_I,
  input  wire logic                TEST_PULSE_I,
  output logic                     SER_DATA_O,
  output logic      [CHANNELS-1:0] CHAN_OUT_O,
  output logic      [CHANNELS-1:0] CAL_INJECT_O,
  output logic      [CAP_W-1:0]    CAP_SELECT_O,
  output logic      [THR_W-1:0]    TIMING_THRESH_LEVEL_O,
  output logic      [QTHR_W-1:0]   CHARGE_THRESH_LEVEL_O,
  output logic      [HYST_W-1:0]   HYSTERESIS_LEVEL_O,
  output logic      [GATE_W-1:0]   GATE_LEVEL_O,
  output logic      [RUND_W-1:0]   RUNDOWN_LEVEL_O,
  output logic      [DEAD_W-1:0]   DEADTIME_LEVEL_O,
  output logic                     TOT_MODE_O
);
  generate
    if (CHANNELS != NUM_CHAN)
    begin : g_bad_chan
      $error("scc_top field map serves exactly eight channels");
    end
  endgenerate

  // Pulls a field whose LSB sits at the highest index, MSB first in chain.
  function automatic logic [7:0] field_get
  (
    input logic [DATA_BITS-1:0] cfg,
    input int                   lsb,
    input int                   width
  );
    logic [7:0] val;
    val = 8'h00;
    for (int j = 0; j < 8; j++)
    begin
      if (j < width)
        val[j] = cfg[lsb-j];
    end
    return val;
  endfunction : field_get

  // Two-bit output mode of one channel, lower index as the high bit.
  function automatic logic [1:0] mode_get
  (
    input logic [DATA_BITS-1:0] cfg,
    input int                   chan
  );
    logic [7:0] val;
    val = field_get(cfg, MODE_POS + MODE_W*chan + 1, MODE_W);
    return val[1:0];
  endfunction : mode_get

  logic [DATA_BITS-1:0]  data_cells_reg;
  logic                  out_cell_reg;
  logic [CHAIN_LEN-1:0]  chain_reg;
  logic [DATA_BITS-1:0]  configuration_shadow_chain_reg;
  logic [DATA_BITS-1:0]  chain_data;
  logic [DATA_BITS-2:0]  chain_low;
  logic [DATA_BITS-1:0]  cfg_sync;
  logic [CHANNELS:0]     pin_sync;
  logic [CHANNELS-1:0]   chan_out_reg;
  logic [CHANNELS-1:0]   inject_reg;
  logic [DATA_BITS-1:0]  cfg_reg;
  logic [7:0]            cap_f;
  logic [7:0]            thr_f;
  logic [7:0]            qthr_f;
  logic [7:0]            hyst_f;
  logic [7:0]            gate_f;
  logic [7:0]            rund_f;
  logic [7:0]            dead_f;

  // Whole chain view: the output cell sits above the fifty-three data cells.
  assign chain_reg  = {out_cell_reg, data_cells_reg};
  assign chain_data = chain_reg[DATA_BITS-1:0];
  assign chain_low  = chain_reg[DATA_BITS-2:0];

  // Data cells on the rising serial edge; readback beats advance beats
  // retain, and cell zero takes the incoming serial bit.
  always_ff @(posedge SER_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      data_cells_reg <= CHAIN_RESET[DATA_BITS-1:0];
    else if (READBACK_CONTROL_LINE_I)
      data_cells_reg <= configuration_shadow_chain_reg;
    else if (ADVANCE_CONTROL_LINE_I)
      data_cells_reg <= {chain_low, SER_DATA_I};
    else
      data_cells_reg <= data_cells_reg;
  end

  // Final cell runs on the falling edge so the output changes there; it
  // holds through a readback copy or a retain and on an advance takes the last data cell.
  always_ff @(negedge SER_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      out_cell_reg <= CHAIN_RESET[OUT_CELL];
    else if (READBACK_CONTROL_LINE_I)
      out_cell_reg <= out_cell_reg;
    else if (ADVANCE_CONTROL_LINE_I)
      out_cell_reg <= data_cells_reg[DATA_BITS-1];
    else
      out_cell_reg <= out_cell_reg;
  end

  // Serial output goes to the next chip or back to the controller.
  assign SER_DATA_O = out_cell_reg;

  // Transparent shadow latches; only the apply line opens them, so shifts
  // and readbacks leave the active settings alone.
  always_latch
  begin
    if (!RST_N_I)
      configuration_shadow_chain_reg <= SHADOW_RESET;
    else if (APPLY_CONTROL_LINE_I)
      configuration_shadow_chain_reg <= chain_data;
  end

  // Settings cross into the core clock as one word.
  scc_sync #(
    .WIDTH   (DATA_BITS)
  ) u_cfg_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .in_i    (configuration_shadow_chain_reg),
    .out_o   (cfg_sync)
  );

  // Channel hits and the test pulse come from pins and are synchronised.
  scc_sync #(
    .WIDTH   (CHANNELS + 1)
  ) u_pin_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .in_i    ({TEST_PULSE_I, CHAN_HIT_I}),
    .out_o   (pin_sync)
  );

  // Working copy of the settings in the core domain.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      cfg_reg <= SHADOW_RESET;
    else
      cfg_reg <= cfg_sync;
  end

  // Field extraction, most significant bit at the lowest chain index.
  assign cap_f  = field_get(cfg_reg, CAP_LSB, CAP_W);
  assign thr_f  = field_get(cfg_reg, THR_LSB, THR_W);
  assign qthr_f = field_get(cfg_reg, QTHR_LSB, QTHR_W);
  assign hyst_f = field_get(cfg_reg, HYST_LSB, HYST_W);
  assign gate_f = field_get(cfg_reg, GATE_LSB, GATE_W);
  assign rund_f = field_get(cfg_reg, RUND_LSB, RUND_W);
  assign dead_f = field_get(cfg_reg, DEAD_LSB, DEAD_W);

  // Converter drive levels; rundown and charge threshold run inverted so a
  // code of all ones gives their lowest level.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      CAP_SELECT_O          <= '0;
      TIMING_THRESH_LEVEL_O <= '0;
      CHARGE_THRESH_LEVEL_O <= '1;
      HYSTERESIS_LEVEL_O    <= '0;
      GATE_LEVEL_O          <= '0;
      RUNDOWN_LEVEL_O       <= '1;
      DEADTIME_LEVEL_O      <= '0;
      TOT_MODE_O            <= 1'b0;
    end
    else
    begin
      CAP_SELECT_O          <= cap_f[CAP_W-1:0];
      TIMING_THRESH_LEVEL_O <= thr_f[THR_W-1:0];
      CHARGE_THRESH_LEVEL_O <= ~qthr_f[QTHR_W-1:0];
      HYSTERESIS_LEVEL_O    <= hyst_f[HYST_W-1:0];
      GATE_LEVEL_O          <= gate_f[GATE_W-1:0];
      RUNDOWN_LEVEL_O       <= ~rund_f[RUND_W-1:0];
      DEADTIME_LEVEL_O      <= dead_f[DEAD_W-1:0];
      TOT_MODE_O            <= cfg_reg[CHIP_POS];
    end
  end

  // Per-channel output: forced low, forced high, or the synchronised hit.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      chan_out_reg <= '0;
    else
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        case (mode_get(cfg_reg, c))
          MODE_FORCED_LOW:  chan_out_reg[c] <= 1'b0;
          MODE_FORCED_HIGH: chan_out_reg[c] <= 1'b1;
          default:          chan_out_reg[c] <= pin_sync[c];
        endcase
      end
    end
  end

  // Test pulses reach only the channels whose mask bit is set.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      inject_reg <= '0;
    else
    begin
      for (int c = 0; c < CHANNELS; c++)
        inject_reg[c] <= cfg_reg[MASK_POS+c] & pin_sync[CHANNELS];
    end
  end

  assign CHAN_OUT_O   = chan_out_reg;
  assign CAL_INJECT_O = inject_reg;

  // Assertion helpers in the serial domain.
  sequence adv_only_s;
    ADVANCE_CONTROL_LINE_I && !READBACK_CONTROL_LINE_I;
  endsequence

  sequence retain_s;
    !ADVANCE_CONTROL_LINE_I && !READBACK_CONTROL_LINE_I;
  endsequence

  chain_advance_a: assert property (
    @(posedge SER_CLK_I) disable iff (!RST_N_I)
    adv_only_s |=> (chain_reg[DATA_BITS-1:1] == $past(chain_low))
      && (chain_reg[0] == $past(SER_DATA_I)))
    else $error("chain did not advance by one cell");

  chain_retain_a: assert property (
    @(posedge SER_CLK_I) disable iff (!RST_N_I)
    retain_s |=> $stable(chain_data))
    else $error("chain changed while retaining");

  readback_copy_a: assert property (
    @(posedge SER_CLK_I) disable iff (!RST_N_I)
    (READBACK_CONTROL_LINE_I && !APPLY_CONTROL_LINE_I)
      |=> chain_data == $past(configuration_shadow_chain_reg))
    else $error("readback did not copy shadow into chain");

  serial_out_a: assert property (
    @(negedge SER_CLK_I) disable iff (!RST_N_I)
    adv_only_s |=> SER_DATA_O == $past(chain_reg[DATA_BITS-1]))
    else $error("output cell missed the last data cell");

  out_hold_a: assert property (
    @(negedge SER_CLK_I) disable iff (!RST_N_I)
    READBACK_CONTROL_LINE_I |=> $stable(SER_DATA_O))
    else $error("output cell moved during readback");

  // Apply is asynchronous and the serial clock may be stopped while it is
  // high, so these two watch the latches from the free-running core clock.
  apply_follow_a: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    APPLY_CONTROL_LINE_I |-> configuration_shadow_chain_reg == chain_data)
    else $error("shadow not following chain while applied");

  shadow_keep_a: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (!APPLY_CONTROL_LINE_I)[*2] |-> $stable(configuration_shadow_chain_reg))
    else $error("shadow changed without apply");

  forced_high_a: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    mode_get(cfg_reg, 0) == MODE_FORCED_HIGH |=> CHAN_OUT_O[0])
    else $error("forced-high channel not high");

  forced_low_a: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    mode_get(cfg_reg, 1) == MODE_FORCED_LOW |=> !CHAN_OUT_O[1])
    else $error("forced-low channel not low");

  mask_gate_a: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    !cfg_reg[MASK_POS] |=> !CAL_INJECT_O[0])
    else $error("masked channel received a test pulse");

  rundown_inv_a: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (rund_f[RUND_W-1:0] == '1) |=> RUNDOWN_LEVEL_O == '0)
    else $error("rundown all-ones code not lowest level");
endmodule : scc_top

//--- src/scc_pkg.sv
// Purpose: Shared constants for the serial configuration chain.
// Assumes: Chain cell k holds configuration bit k; bit 0 enters last.
// Notes:   Multi-bit fields sit with their MSB at the lowest index.
package scc_pkg;
  localparam int CHAIN_LEN   = 54;
  localparam int DATA_BITS   = 53;
  localparam int NUM_CHAN    = 8;
  localparam int OUT_CELL    = 53;
  localparam int MASK_POS    = 0;
  localparam int CAP_LSB     = 10;
  localparam int CAP_W       = 3;
  localparam int THR_LSB     = 18;
  localparam int THR_W       = 8;
  localparam int QTHR_LSB    = 21;
  localparam int QTHR_W      = 3;
  localparam int HYST_LSB    = 25;
  localparam int HYST_W      = 4;
  localparam int GATE_LSB    = 29;
  localparam int GATE_W      = 4;
  localparam int RUND_LSB    = 32;
  localparam int RUND_W      = 3;
  localparam int DEAD_LSB    = 35;
  localparam int DEAD_W      = 3;
  localparam int MODE_POS    = 36;
  localparam int MODE_W      = 2;
  localparam int CHIP_POS    = 52;
  localparam int SYNC_STAGES = 3;
  localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = {CHAIN_LEN{1'b0}};
  localparam logic [DATA_BITS-1:0] SHADOW_RESET = {DATA_BITS{1'b0}};
  localparam logic [1:0] MODE_FORCED_LOW  = 2'h2;
  localparam logic [1:0] MODE_FORCED_HIGH = 2'h3;
endpackage : scc_pkg

//--- src/scc_sync.sv
// Purpose: Three-stage synchroniser for a group of bits from another domain.
// Assumes: Inputs are quasi-static levels relative to the sampling clock.
// Notes:   The group updates only once stages two and three agree in full.
`timescale 1ns/1ps
module scc_sync
  import scc_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_i,
  output logic      [WIDTH-1:0] out_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("scc_sync needs a width of at least one");
    end
  endgenerate

  // Three-flop pipe; only the second stage reads the first.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= in_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a new value once the last two stages agree, so a word in flux
  // is never passed on half-changed.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_reg <= '0;
    else if (s2_reg == s3_reg)
      out_reg <= s3_reg;
  end

  assign out_o = out_reg;
endmodule : scc_sync

//--- test/scc_ctrl_model.sv
// Purpose: Behavioural configuration controller for the serial chain.
// Assumes: Serial clock period of 64 ns, stopped low between frames.
// Notes:   Lines change 1 ns after a falling edge, away from the rise.
`timescale 1ns/1ps
module scc_ctrl_model (
  output logic      ser_clk_o,
  output logic      ser_data_o,
  output logic      advance_o,
  output logic      readback_o,
  output logic      apply_o,
  input  wire logic ser_data_i
);
  // The link idles with its clock stopped and no instruction active.
  initial
  begin
    ser_clk_o  = 1'b0;
    ser_data_o = 1'b0;
    advance_o  = 1'b0;
    readback_o = 1'b0;
    apply_o    = 1'b0;
  end

  // One serial period that returns just after the falling edge.
  task automatic pulse();
    #31 ser_clk_o = 1'b1;
    #32 ser_clk_o = 1'b0;
    #1;
  endtask : pulse

  // Optional readback copy, 53 shifts out and in, then three idle holds.
  task automatic frame(input logic [52:0] word, input logic rb,
                       output logic [52:0] seen);
    int k;
    if (rb)
    begin
      readback_o = 1'b1;
      pulse();
      readback_o = 1'b0;
    end
    advance_o = 1'b1;
    for (k = 1; k <= 53; k++)
    begin
      ser_data_o = word[53-k]; // Bit 52 first, bit 0 last.
      // The returning bit stands from the last fall, so it is read before
      // the next rise moves the chain on.
      seen[53-k] = ser_data_i; // Returning loop data.
      pulse();
    end
    advance_o  = 1'b0;
    ser_data_o = ~ser_data_o; // Idle data is not left at the last bit.
    repeat (3) pulse();
  endtask : frame

  // Apply pulse, dropped again before any further shifting.
  task automatic apply();
    apply_o = 1'b1;
    #40;
    apply_o = 1'b0;
  endtask : apply
endmodule : scc_ctrl_model

//--- test/scc_top_tb_top.sv
// Purpose: Self-checking bench for the serial configuration chain.
// Assumes: Settings reach the core outputs within 12 core clocks.
// Notes:   The controller model closes the loop from output to input.
`timescale 1ns/1ps
module scc_top_tb_top;
  logic        core_clk;
  logic        rst_n;
  logic        ser_clk;
  logic        ser_din;
  logic        adv;
  logic        rdb;
  logic        apl;
  logic        tp;
  logic        ser_dout;
  logic        time_over_threshold_mode;
  logic [7:0]  hit;
  logic [7:0]  chan_out;
  logic [7:0]  cal_inject;
  logic [7:0]  thr;
  logic [2:0]  cap;
  logic [2:0]  qthr;
  logic [2:0]  rund;
  logic [2:0]  dead;
  logic [3:0]  hyst;
  logic [3:0]  gate;
  logic [52:0] words [4];
  logic [52:0] seen;
  int          failures;
  int          n_tests;
  int          i;
  int          c;

  scc_top scc_top_inst (
    .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .SER_CLK_I(ser_clk),
    .SER_DATA_I(ser_din), .ADVANCE_CONTROL_LINE_I(adv),
    .READBACK_CONTROL_LINE_I(rdb), .APPLY_CONTROL_LINE_I(apl),
    .CHAN_HIT_I(hit), .TEST_PULSE_I(tp), .SER_DATA_O(ser_dout),
    .CHAN_OUT_O(chan_out), .CAL_INJECT_O(cal_inject),
    .CAP_SELECT_O(cap), .TIMING_THRESH_LEVEL_O(thr),
    .CHARGE_THRESH_LEVEL_O(qthr), .HYSTERESIS_LEVEL_O(hyst),
    .GATE_LEVEL_O(gate), .RUNDOWN_LEVEL_O(rund),
    .DEADTIME_LEVEL_O(dead), .TOT_MODE_O(time_over_threshold_mode)
  );

  scc_ctrl_model scc_ctrl_model_inst (
    .ser_clk_o(ser_clk), .ser_data_o(ser_din), .advance_o(adv),
    .readback_o(rdb), .apply_o(apl), .ser_data_i(ser_dout)
  );

  // Core clock of 20 ns.
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Counts every comparison and reports each mismatch.
  task automatic chk(input string name, input logic [63:0] seen_v,
                     input logic [63:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : chk

  // Gathers a field whose least significant bit sits at the highest index.
  function automatic logic [7:0] fld(input logic [52:0] w, input int lsb,
                                     input int wd);
    int j;
    fld = 8'h00;
    for (j = 0; j < wd; j++)
      fld[j] = w[lsb-j];
  endfunction : fld

  // Waits for the settings to cross, then compares every decoded output.
  task automatic check_cfg(input logic [52:0] w);
    logic [7:0] ch;
    int         k;
    repeat (12) @(posedge core_clk);
    for (k = 0; k < 8; k++)
      ch[k] = w[36+2*k] ? w[37+2*k] : hit[k];
    chk("cal_inject", 64'(cal_inject), 64'(w[7:0]));
    chk("cap", 64'(cap), 64'(fld(w, 10, 3)));
    chk("thr", 64'(thr), 64'(fld(w, 18, 8)));
    chk("qthr", 64'(qthr), 64'(~fld(w, 21, 3) & 8'h07));
    chk("hyst", 64'(hyst), 64'(fld(w, 25, 4)));
    chk("gate", 64'(gate), 64'(fld(w, 29, 4)));
    chk("rund", 64'(rund), 64'(~fld(w, 32, 3) & 8'h07));
    chk("dead", 64'(dead), 64'(fld(w, 35, 3)));
    chk("chan_out", 64'(chan_out), 64'(ch));
    chk("tot", 64'(time_over_threshold_mode), 64'(w[52]));
  endtask : check_cfg

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Cuts a hung run short as a failure.
  initial
  begin
    #1000000;
    failures++;
    end_sim();
  end

  // Main sequence: reset, four frames, readback and applies.
  initial
  begin
    rst_n    = 1'b1;
    hit      = 8'h5a;
    tp       = 1'b1;
    failures = 0;
    n_tests  = 0;
    words[0] = 53'h1_2345_6789_abcd;
    words[1] = ~words[0];
    words[2] = 53'h1_f0f0_5a5a_3c3c;
    words[3] = 53'h1_c3a5_0ff0_9669;
    for (i = 0; i < 4; i++)
      for (c = 0; c < 8; c++)
        {words[i][36+2*c], words[i][37+2*c]} = 2'((c + i) % 4);
    // An all-ones rundown code reaches the outputs in the last setting.
    words[3][32:30] = 3'h7;
    // Reset is raised on a clock edge, once every process is waiting.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rst_qthr", 64'(qthr), 64'(3'h7));
    chk("rst_rund", 64'(rund), 64'(3'h7));
    chk("rst_thr", 64'(thr), 64'(8'h00));
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    scc_ctrl_model_inst.frame(words[0], 1'b0, seen);
    chk("loop_first", 64'(seen), 64'(53'h0));
    scc_ctrl_model_inst.apply();
    check_cfg(words[0]);
    scc_ctrl_model_inst.frame(words[1], 1'b0, seen);
    chk("loop_shift", 64'(seen), 64'(words[0]));
    check_cfg(words[0]);
    scc_ctrl_model_inst.apply();
    check_cfg(words[1]);
    scc_ctrl_model_inst.frame(words[2], 1'b0, seen);
    scc_ctrl_model_inst.frame(words[3], 1'b1, seen);
    chk("readback", 64'(seen[51:0]), 64'(words[1][51:0]));
    chk("rb_stale", 64'(seen[52]), 64'(words[2][52]));
    check_cfg(words[1]);
    scc_ctrl_model_inst.apply();
    check_cfg(words[3]);
    end_sim();
  end
endmodule : scc_top_tb_top
